// file: verilog/rcm_defs.svh
// register map, field positions, reset values and timing counts of the mode control block
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH
// register byte offsets
`define RCM_OFF_CTRL    8'h00
`define RCM_OFF_FREQ    8'h04
`define RCM_OFF_TRIM    8'h08
`define RCM_OFF_FBDIV   8'h0C
`define RCM_OFF_BW      8'h10
`define RCM_OFF_STATUS  8'h14
`define RCM_OFF_PHERR   8'h18
`define RCM_OFF_FBADJ   8'h1C
// control register fields
`define RCM_CTRL_W      5
`define RCM_CTRL_INBUF  0
`define RCM_CTRL_OSTART 1
`define RCM_CTRL_LOCK   2
`define RCM_CTRL_DPLL   3
`define RCM_CTRL_REFSRC 4
`define RCM_CTRL_RST    5'h00
// other reset values and widths
`define RCM_FBDIV_W     8
`define RCM_FBDIV_RST   8'h64
`define RCM_BW_W        4
`define RCM_BW_RST      4'h8
`define RCM_SCALE_LSB   8
`define RCM_ERR_W       16
`define RCM_FILT_W      24
`define RCM_NBLK        4
// status register fields
`define RCM_ST_DONE     0
`define RCM_ST_FAIL     1
`define RCM_ST_JA       2
`define RCM_ST_BLK      4
// gap between two block releases
`define RCM_CLK_NS      10
`define RCM_STAGE_NS    100
`define RCM_STAGE_CYC   ((`RCM_STAGE_NS + `RCM_CLK_NS - 1) / `RCM_CLK_NS)
`define RCM_GAP_W       4
`endif

// file: verilog/rcm_pkg.sv
// types shared by the mode and startup control block
`default_nettype none
package rcm_pkg;
	// startup sequencer states
	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_STAGE,
		SEQ_CAL,
		SEQ_RUN
	} rcm_seq_t;
endpackage : rcm_pkg
`default_nettype wire

// file: verilog/rcm_ctrl.sv
// clock mode selection, oscillator control, digital loop and startup reset sequencing
`include "rcm_defs.svh"
`default_nettype none
module rcm_ctrl
	import rcm_pkg::*;
(
	input  wire logic                 clk_in,           // system clock, 100 MHz
	input  wire logic                 nrst_in,          // asynchronous reset, active low
	input  wire logic                 hsel_in,          // ahb slave select
	input  wire logic [31:0]          haddr_in,         // ahb address
	input  wire logic [1:0]           htrans_in,        // ahb transfer type
	input  wire logic                 hwrite_in,        // ahb write
	input  wire logic [2:0]           hsize_in,         // ahb size, words only
	input  wire logic [31:0]          hwdata_in,        // ahb write data
	input  wire logic                 hready_in,        // ahb bus ready
	output logic                      hreadyout_out,    // ahb slave ready
	output logic                      hresp_out,        // ahb response, always okay
	output logic [31:0]               hrdata_out,       // ahb read data
	input  wire logic                 regs_stable_in,   // regulators report stable
	input  wire logic                 cal_finish_in,    // bias calibration finished pulse
	input  wire logic                 cal_error_in,     // bias calibration problem
	input  wire logic                 ref_tick_in,      // reference clock edge pulse
	input  wire logic                 fb_tick_in,       // analog loop output edge pulse
	output logic [`RCM_NBLK-1:0]      blk_rst_n_out,    // per block reset, active low
	output logic                      ref_pad_en_out,   // reference input pad enable
	output logic                      ref_src_sel_out,  // 0 crystal, 1 reference input
	output logic                      dpll_pwr_en_out,  // digital loop power enable
	output logic                      jitter_cleanup_mode_out, // cleanup mode active
	output logic [31:0]               fb_adjust_out     // feedback divider adjustment
);
	// reset release through two flops
	logic                      rst_s1_r;         // first reset stage
	logic                      rst_n;            // synchronised reset
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// bus state
	logic                      ph_r, ph_nxt;     // data phase pending
	logic                      wr_r, wr_nxt;     // pending access is a write
	logic                      rdw_r, rdw_nxt;   // read wait cycle done
	logic [7:0]                adr_r, adr_nxt;   // pending byte offset
	logic [31:0]               rd_r, rd_nxt;     // read data register
	// software registers
	logic [`RCM_CTRL_W-1:0]    ctrl_r, ctrl_nxt;   // mode controls
	logic [31:0]               freq_r, freq_nxt;   // control word, lsb 2^-40
	logic [31:0]               trim_r, trim_nxt;   // crystal offset trim
	logic [`RCM_FBDIV_W-1:0]   fbdiv_r, fbdiv_nxt; // feedback divide ratio
	logic [`RCM_BW_W-1:0]      bw_r, bw_nxt;       // loop filter shift
	// derived signals
	logic                      ja;               // cleanup mode active
	logic                      wr_go;            // write data phase ends
	logic                      rd_go;            // read data is being loaded
	logic [31:0]               status;           // status word
	logic [31:0]               rd_mux;           // read selection

	// cleanup mode needs inbuf, ostart, lock and dpll set; refsrc plays no part
	assign ja = ctrl_r[`RCM_CTRL_INBUF] & ctrl_r[`RCM_CTRL_OSTART]
		& ctrl_r[`RCM_CTRL_LOCK] & ctrl_r[`RCM_CTRL_DPLL];
	assign wr_go = ph_r & wr_r;
	assign rd_go = ph_r & !wr_r & !rdw_r;
	assign hreadyout_out = !(ph_r & !wr_r & !rdw_r);
	assign hresp_out = 1'b0;
	assign hrdata_out = rd_r;

	// sequencer and calibration state
	rcm_seq_t                  seq_r, seq_nxt;   // startup state
	logic [1:0]                idx_r, idx_nxt;   // next block to release
	logic [`RCM_GAP_W-1:0]     gap_r, gap_nxt;   // release spacing counter
	logic [`RCM_NBLK-1:0]      blk_r, blk_nxt;   // block reset lines
	logic                      done_r, done_nxt; // calibration complete
	logic                      fail_r, fail_nxt; // calibration failure
	// digital loop state, declared ahead of the read mux that shows it
	logic signed [`RCM_ERR_W-1:0]  err_r, err_nxt;   // phase error count
	logic signed [`RCM_FILT_W-1:0] filt_r, filt_nxt; // filtered error
	logic signed [`RCM_FILT_W-1:0] diff;             // error minus filter
	logic [39:0]                   prod;             // word times ratio
	logic [31:0]                   adj_r, adj_nxt;   // applied adjustment
	// a one-bit signed literal would read as minus one, so the step is sized
	localparam logic signed [`RCM_ERR_W-1:0] ERR_ONE = `RCM_ERR_W'(1); // one phase step

	// status and read mux
	always_comb begin
		status = '0;
		status[`RCM_ST_DONE] = done_r;
		status[`RCM_ST_FAIL] = fail_r;
		status[`RCM_ST_JA]   = ja;
		status[`RCM_ST_BLK +: `RCM_NBLK] = blk_r;
		rd_mux = '0;
		unique case (adr_r)
			`RCM_OFF_CTRL:   rd_mux[`RCM_CTRL_W-1:0] = ctrl_r;
			`RCM_OFF_FREQ:   rd_mux = freq_r;
			`RCM_OFF_TRIM:   rd_mux = trim_r;
			`RCM_OFF_FBDIV:  rd_mux[`RCM_FBDIV_W-1:0] = fbdiv_r;
			`RCM_OFF_BW:     rd_mux[`RCM_BW_W-1:0] = bw_r;
			`RCM_OFF_STATUS: rd_mux = status;
			`RCM_OFF_PHERR:  rd_mux = 32'(signed'(err_r));
			`RCM_OFF_FBADJ:  rd_mux = fb_adjust_out;
			default:         rd_mux = '0; // unmapped reads zero
		endcase
	end

	// bus and register next values
	always_comb begin
		ph_nxt   = ph_r;
		wr_nxt   = wr_r;
		adr_nxt  = adr_r;
		rdw_nxt  = rdw_r;
		rd_nxt   = rd_r;
		ctrl_nxt = ctrl_r;
		freq_nxt = freq_r;
		trim_nxt = trim_r;
		fbdiv_nxt = fbdiv_r;
		bw_nxt   = bw_r;
		// data phase: reads take one wait cycle to load the flop
		if (rd_go) begin
			rd_nxt  = rd_mux;
			rdw_nxt = 1'b1;
		end
		if (wr_go) begin
			unique case (adr_r)
				`RCM_OFF_CTRL:  ctrl_nxt = hwdata_in[`RCM_CTRL_W-1:0];
				`RCM_OFF_FREQ:  if (!ja) freq_nxt = hwdata_in;
				`RCM_OFF_TRIM:  trim_nxt = hwdata_in;
				`RCM_OFF_FBDIV: fbdiv_nxt = hwdata_in[`RCM_FBDIV_W-1:0];
				`RCM_OFF_BW:    bw_nxt = hwdata_in[`RCM_BW_W-1:0];
				default:        ; // status and others ignore writes
			endcase
		end
		if (hreadyout_out) begin
			ph_nxt  = hsel_in & hready_in & htrans_in[1];
			wr_nxt  = hwrite_in;
			adr_nxt = haddr_in[7:0];
			rdw_nxt = 1'b0;
		end
	end

	// bus and register flops
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ph_r    <= 1'b0;
			wr_r    <= 1'b0;
			rdw_r   <= 1'b0;
			adr_r   <= 8'h00;
			rd_r    <= 32'h0;
			ctrl_r  <= `RCM_CTRL_RST;
			freq_r  <= 32'h0;
			trim_r  <= 32'h0;
			fbdiv_r <= `RCM_FBDIV_RST;
			bw_r    <= `RCM_BW_RST;
		end else begin
			ph_r    <= ph_nxt;
			wr_r    <= wr_nxt;
			rdw_r   <= rdw_nxt;
			adr_r   <= adr_nxt;
			rd_r    <= rd_nxt;
			ctrl_r  <= ctrl_nxt;
			freq_r  <= freq_nxt;
			trim_r  <= trim_nxt;
			fbdiv_r <= fbdiv_nxt;
			bw_r    <= bw_nxt;
		end
	end

	// startup sequencer: hold, release bias, calibrate, release the rest
	always_comb begin
		seq_nxt  = seq_r;
		idx_nxt  = idx_r;
		gap_nxt  = gap_r;
		blk_nxt  = blk_r;
		done_nxt = done_r;
		fail_nxt = fail_r;
		unique case (seq_r)
			SEQ_HOLD: begin
				if (regs_stable_in) begin
					seq_nxt = SEQ_STAGE;
					gap_nxt = '0;
				end
			end
			SEQ_STAGE: begin
				if (gap_r == `RCM_GAP_W'(`RCM_STAGE_CYC - 1)) begin
					blk_nxt[idx_r] = 1'b1;
					gap_nxt = '0;
					idx_nxt = idx_r + 2'd1;
					if (idx_r == 2'd0)
						seq_nxt = SEQ_CAL;
					else if (idx_r == 2'(`RCM_NBLK - 1))
						seq_nxt = SEQ_RUN;
				end else begin
					gap_nxt = gap_r + 1'b1;
				end
			end
			SEQ_CAL: begin
				if (cal_finish_in) begin
					done_nxt = 1'b1;
					if (cal_error_in)
						fail_nxt = 1'b1;
					seq_nxt = SEQ_STAGE; // startup goes on either way
				end
			end
			SEQ_RUN: ;
		endcase
		// regulators dropping puts every block back in reset
		if (!regs_stable_in) begin
			seq_nxt = SEQ_HOLD;
			blk_nxt = '0;
			idx_nxt = '0;
		end
	end

	// sequencer flops
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			seq_r  <= SEQ_HOLD;
			idx_r  <= 2'd0;
			gap_r  <= '0;
			blk_r  <= '0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
		end else begin
			seq_r  <= seq_nxt;
			idx_r  <= idx_nxt;
			gap_r  <= gap_nxt;
			blk_r  <= blk_nxt;
			done_r <= done_nxt;
			fail_r <= fail_nxt;
		end
	end
	assign blk_rst_n_out = blk_r;

	// digital loop and feedback adjustment
	always_comb begin
		err_nxt  = '0;
		filt_nxt = '0;
		diff     = `RCM_FILT_W'(err_r) - filt_r;
		prod     = freq_r * fbdiv_r;
		if (ja) begin
			// count reference edges up and output edges down
			err_nxt = err_r;
			if (ref_tick_in & !fb_tick_in)
				err_nxt = err_r + ERR_ONE;
			else if (fb_tick_in & !ref_tick_in)
				err_nxt = err_r - ERR_ONE;
			filt_nxt = filt_r + (diff >>> bw_r);
			adj_nxt  = 32'(filt_r) + trim_r;
		end else begin
			// loop bypassed, reference ignored
			adj_nxt = prod[`RCM_SCALE_LSB +: 32] + trim_r;
		end
	end

	// loop flops
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			err_r  <= '0;
			filt_r <= '0;
			adj_r  <= 32'h0;
		end else begin
			err_r  <= err_nxt;
			filt_r <= filt_nxt;
			adj_r  <= adj_nxt;
		end
	end
	assign fb_adjust_out = adj_r;
	assign ref_pad_en_out = ctrl_r[`RCM_CTRL_INBUF];
	assign ref_src_sel_out = ctrl_r[`RCM_CTRL_REFSRC];
	assign dpll_pwr_en_out = ctrl_r[`RCM_CTRL_DPLL];
	assign jitter_cleanup_mode_out = ja;

	// checks
	localparam int STAGE_GAP = `RCM_STAGE_CYC; // release spacing in cycles
	sequence s_rd_addr;
		hreadyout_out && hsel_in && hready_in && htrans_in[1] && !hwrite_in;
	endsequence
	sequence s_rd_data;
		!hreadyout_out ##1 hreadyout_out;
	endsequence
	a_read_wait_state: assert property (@(posedge clk_in) disable iff (!rst_n)
		s_rd_addr |=> s_rd_data) else $error("read did not take one wait cycle");
	a_hold_until_stable: assert property (@(posedge clk_in) disable iff (!rst_n)
		!regs_stable_in |=> blk_r == '0) else $error("block released before stable");
	a_release_order: assert property (@(posedge clk_in) disable iff (!rst_n)
		blk_r inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}) else $error("release order broken");
	a_cal_done_set: assert property (@(posedge clk_in) disable iff (!rst_n)
		seq_r == SEQ_CAL && cal_finish_in && regs_stable_in |=> done_r && seq_r == SEQ_STAGE)
		else $error("calibration done not set");
	a_cal_fail_on: assert property (@(posedge clk_in) disable iff (!rst_n)
		seq_r == SEQ_CAL && cal_finish_in && cal_error_in && regs_stable_in
		|=> fail_r ##[1:STAGE_GAP] blk_r[1]) else $error("failure halted startup");
	a_flags_ro: assert property (@(posedge clk_in) disable iff (!rst_n)
		wr_go && seq_r != SEQ_CAL |=> $stable(done_r) && $stable(fail_r))
		else $error("host write changed calibration flags");
	a_dco_scaled: assert property (@(posedge clk_in) disable iff (!rst_n)
		!ja |=> adj_r == $past(prod[`RCM_SCALE_LSB +: 32]) + $past(trim_r))
		else $error("control word not scaled onto divider");
	a_loop_bypass: assert property (@(posedge clk_in) disable iff (!rst_n)
		!ja |=> err_r == '0 && filt_r == '0) else $error("digital loop active in synth mode");
	a_word_locked: assert property (@(posedge clk_in) disable iff (!rst_n)
		ja && wr_go && adr_r == `RCM_OFF_FREQ |=> $stable(freq_r))
		else $error("control word written in cleanup mode");
	a_err_count: assert property (@(posedge clk_in) disable iff (!rst_n)
		ja && ref_tick_in && !fb_tick_in |=> err_r == $past(err_r) + ERR_ONE)
		else $error("phase error not counted");
	a_default_synth: assert property (@(posedge clk_in)
		$rose(rst_n) |-> !ja && !ref_pad_en_out) else $error("reset not in synth mode");
endmodule : rcm_ctrl
`default_nettype wire

// file: test/rcm_host.sv
// bus master model standing in for the host processor
`default_nettype none
module rcm_host (
	input  wire logic        clk_in,     // system clock
	input  wire logic        hready_in,  // bus ready
	input  wire logic [31:0] hrdata_in,  // read data
	output logic      [31:0] haddr_out,  // address
	output logic      [1:0]  htrans_out, // transfer type
	output logic             hwrite_out, // write flag
	output logic      [31:0] hwdata_out  // write data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        rdy_q; // ready as sampled at the edge
	logic [31:0] rd_q;  // read data as sampled at the edge
	// bus idle from time zero
	initial begin
		haddr_out  = 32'h0;
		htrans_out = 2'h0;
		hwrite_out = 1'b0;
		hwdata_out = 32'h0;
	end
	// sample answer lines at each rising edge
	always @(posedge clk_in) begin
		rdy_q <= hready_in;
		rd_q  <= hrdata_in;
	end
	// hold until an edge saw the slave ready
	task automatic wait_rdy;
		do begin
			@(posedge clk_in);
			#1;
		end while (rdy_q !== 1'b1);
	endtask : wait_rdy
	// one single word transfer, address phase then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		haddr_out  <= {24'h0, a};
		hwrite_out <= wr;
		htrans_out <= 2'h2;
		wait_rdy();
		htrans_out <= 2'h0;
		hwdata_out <= wd;
		wait_rdy();
		rdat = rd_q;
	endtask : xfer
endmodule : rcm_host
`default_nettype wire

// file: test/rcm_ctrl_tb.sv
// self-checking bench of the mode and startup control block
`default_nettype none
module rcm_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} rcm_row_t;
	logic        clk_in  = 1'b0; // 100 MHz clock
	logic        nrst_in = 1'b1; // reset, active low, pulled low at time zero
	logic        stab    = 1'b0; // regulators stable
	logic        cal_fin = 1'b0; // calibration finished pulse
	logic        cal_err = 1'b0; // calibration problem
	logic        ref_tk  = 1'b0; // reference edge pulse
	logic        fb_tk   = 1'b0; // analog loop output edge pulse
	wire  [31:0] haddr, hwdata, hrdata;
	wire  [1:0]  htrans;
	wire         hwrite, hready;
	logic [3:0]  blk, prev;      // block resets
	logic        pad, src, pwr, mode, resp;
	logic [31:0] fbadj, rd;
	int          bad_count = 0;
	int          checks    = 0;
	int          cyc       = 0;
	int          n;
	// register rows: offset, write data, read back
	rcm_row_t rows [7] = '{
		'{8'h04, 32'h12345678, 32'h12345678},
		'{8'h08, 32'h00000010, 32'h00000010},
		'{8'h0C, 32'hFFFFFF02, 32'h00000002},
		'{8'h10, 32'hFFFFFFF0, 32'h00000000},
		'{8'h20, 32'hFFFFFFFF, 32'h00000000},
		'{8'h14, 32'h00000000, 32'h000000F3},
		'{8'h18, 32'h0000FFFF, 32'h00000000}};
	rcm_ctrl u_rcm_ctrl (
		.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(1'b1), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hresp_out(resp), .hrdata_out(hrdata),
		.regs_stable_in(stab), .cal_finish_in(cal_fin), .cal_error_in(cal_err),
		.ref_tick_in(ref_tk), .fb_tick_in(fb_tk), .blk_rst_n_out(blk),
		.ref_pad_en_out(pad), .ref_src_sel_out(src), .dpll_pwr_en_out(pwr),
		.jitter_cleanup_mode_out(mode), .fb_adjust_out(fbadj));
	rcm_host u_rcm_host (
		.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .haddr_out(haddr),
		.htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));
	// clock and hang guard
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	// compare seen against expected
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// settle a number of edges
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : tick
	// register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_rcm_host.xfer(1'b1, a, d, rd);
	endtask : wr
	// register read into rd
	task automatic rdr(input logic [7:0] a);
		u_rcm_host.xfer(1'b0, a, 32'h0, rd);
	endtask : rdr
	// reference edge pulses when up is set, loop output edge pulses otherwise
	task automatic pulses(input int k, input logic up);
		repeat (k) begin
			@(posedge clk_in) {ref_tk, fb_tk} <= {up, !up};
			@(posedge clk_in) {ref_tk, fb_tk} <= 2'b00;
		end
		tick(6);
	endtask : pulses
	// verdict and end of run
	task automatic end_of_test;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		// the falling edge at time zero lets every async reset act before the first clock
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		tick(30);
		chk(32'(blk), 32'h0);
		chk(32'({pad, pwr, mode}), 32'h0);
		chk(32'(resp), 32'h0);
		rdr(8'h00);
		chk(rd, 32'h0);
		@(posedge clk_in) stab <= 1'b1;
		// blocks must leave reset one by one, calibration gates the rest
		for (int k = 1; k <= 4; k++) begin
			prev = blk;
			n = 0;
			while (blk === prev && n < 200) begin
				tick(1);
				n++;
			end
			chk(32'(blk), (32'h1 << k) - 32'h1);
			if (k == 1) begin
				tick(40);
				chk(32'(blk), 32'h1);
				@(posedge clk_in) cal_fin <= 1'b1;
				cal_err <= 1'b1;
				@(posedge clk_in) cal_fin <= 1'b0;
			end
		end
		// ordinary register accesses
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdr(rows[i].a);
			chk(rd, rows[i].e);
		end
		tick(4);
		chk(fbadj, 32'h002468BC);
		wr(8'h00, 32'h1F);
		tick(1);
		chk(32'({pad, src, pwr, mode}), 32'hF);
		wr(8'h04, 32'h0);
		rdr(8'h04);
		chk(rd, 32'h12345678);
		pulses(3, 1'b1);
		rdr(8'h18);
		chk(rd, 32'h3);
		chk(fbadj, 32'h13);
		// one loop output edge alone counts the error back down
		pulses(1, 1'b0);
		rdr(8'h18);
		chk(rd, 32'h2);
		chk(fbadj, 32'h12);
		wr(8'h00, 32'h10);
		pulses(2, 1'b1);
		rdr(8'h18);
		chk(rd, 32'h0);
		chk(32'({src, pwr, mode}), 32'h4);
		chk(fbadj, 32'h002468BC);
		@(posedge clk_in) stab <= 1'b0;
		tick(3);
		chk(32'(blk), 32'h0);
		// reset in mid-run: defaults return and the sticky flags clear
		@(posedge clk_in) nrst_in <= 1'b0;
		tick(2);
		chk(32'({pad, src, pwr, mode, blk}), 32'h0);
		chk(fbadj, 32'h0);
		@(posedge clk_in) nrst_in <= 1'b1;
		tick(4);
		rdr(8'h14);
		chk(rd, 32'h0);
		rdr(8'h00);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule : rcm_ctrl_tb
`default_nettype wire
